//--- logic/kbc_cfg_pkg.sv
// constants, types and helpers shared by the input controller configuration bank
package input_ctrl_cfg_pkg;

  // ***************************************************************
  // bus geometry
  // ***************************************************************
  localparam int WB_ADR_W = 10;
  localparam int WB_DAT_W = 32;
  localparam int IDX_W = 8;
  localparam int REG_W = 8;

  // ***************************************************************
  // register indices (byte address is four times the index)
  // ***************************************************************
  localparam logic [7:0] IDX_DEV_SEL = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_DATA_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_DATA_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_CMD_BASE_HI = 8'h62;
  localparam logic [7:0] IDX_CMD_BASE_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_NO_DMA_A = 8'h74;
  localparam logic [7:0] IDX_NO_DMA_B = 8'h75;
  localparam logic [7:0] IDX_CTRL_CFG = 8'hF0;

  // logical device numbers written into the device select register
  localparam logic [7:0] LD_MOUSE = 8'h05;
  localparam logic [7:0] LD_KEYBOARD = 8'h06;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_DEV_SEL = 8'h00;
  localparam logic RST_MOUSE_ACT = 1'b0;
  localparam logic RST_KBD_ACT = 1'b1;
  localparam logic [7:0] RST_MOUSE_IRQ_NUM = 8'h0C;
  localparam logic [7:0] RST_KBD_IRQ_NUM = 8'h01;
  localparam logic [7:0] RST_IRQ_TYPE = 8'h02;
  localparam logic [7:0] RST_DATA_BASE_HI = 8'h00;
  localparam logic [7:0] RST_DATA_BASE_LO = 8'h60;
  localparam logic [7:0] RST_CMD_BASE_HI = 8'h00;
  localparam logic [7:0] RST_CMD_BASE_LO = 8'h64;
  localparam logic [7:0] RST_CTRL_CFG = 8'h40;
  localparam logic [7:0] NO_DMA_VALUE = 8'h04;

  // ***************************************************************
  // writable masks and fixed bit values
  // ***************************************************************
  localparam logic [7:0] IRQ_TYPE_WMASK = 8'h03;
  localparam logic [7:0] IRQ_TYPE_FIXED = 8'h00;
  localparam logic [7:0] BASE_HI_WMASK = 8'h07;
  localparam logic [7:0] BASE_HI_FIXED = 8'h00;
  localparam logic [7:0] BASE_LO_WMASK = 8'hF8;
  localparam logic [7:0] DATA_BASE_LO_FIXED = 8'h00;
  localparam logic [7:0] CMD_BASE_LO_FIXED = 8'h04;
  localparam logic [7:0] CTRL_CFG_WMASK = 8'hC9;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int ACT_BIT = 0;
  localparam int CFG_CLK_MSB = 7;
  localparam int CFG_CLK_LSB = 6;
  localparam int CFG_SWAP_BIT = 3;
  localparam int CFG_FLOAT_BIT = 0;

  // controller clock source selection
  typedef enum logic [1:0] {
    CLK_8MHZ = 2'b00,
    CLK_12MHZ = 2'b01,
    CLK_16MHZ = 2'b10,
    CLK_RSVD = 2'b11
  } clk_src_t;

  // one open-drain clock/data pin pair
  typedef struct packed {
    logic clk;
    logic dat;
  } ps2_pair_t;

  // interrupt request as seen by the interrupt router
  typedef struct packed {
    logic [7:0] num;
    logic [1:0] kind;
    logic req;
  } irq_out_t;

  // keep protected bits, take writable bits from the bus
  function automatic logic [7:0] wmerge(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] mask);
    wmerge = (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

//--- logic/ps2_pin_router.sv
// pin pair routing, floating and input synchronisation for the input controller
`timescale 1ns/1ps

module ps2_pin_router
  import input_ctrl_cfg_pkg::*;
(
  input wire logic core_clk, // bus clock
  input wire logic nrst, // async reset, active low
  input wire logic swap, // exchange pin pair roles
  input wire logic float_kbd_pins, // release keyboard pin pair
  input wire logic float_mouse_pins, // release pointer pin pair
  input wire ps2_pair_t kbd_role_drive, // core pulls keyboard lines low
  input wire ps2_pair_t mouse_role_drive, // core pulls pointer lines low
  output ps2_pair_t kbd_role_rx, // synchronised keyboard line levels
  output ps2_pair_t mouse_role_rx, // synchronised pointer line levels
  input wire ps2_pair_t kbd_pin_in, // keyboard_clock_pin / keyboard_data_pin level
  output ps2_pair_t kbd_pin_out, // always low, open drain
  output ps2_pair_t kbd_pin_oe, // high while pulling low
  input wire ps2_pair_t ptr_pin_in, // pointer clock / pointer_data_pin level
  output ps2_pair_t ptr_pin_out, // always low, open drain
  output ps2_pair_t ptr_pin_oe // high while pulling low
);

  ps2_pair_t kbd_meta_r;
  ps2_pair_t kbd_sync_r;
  ps2_pair_t ptr_meta_r;
  ps2_pair_t ptr_sync_r;
  ps2_pair_t kbd_oe_r;
  ps2_pair_t ptr_oe_r;

  // open drain: the level driven is always low
  assign kbd_pin_out = '0;
  assign ptr_pin_out = '0;
  assign kbd_pin_oe = kbd_oe_r;
  assign ptr_pin_oe = ptr_oe_r;

  // two-stage synchronisers; first stage is read by the second only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      kbd_meta_r <= '1;
      kbd_sync_r <= '1;
      ptr_meta_r <= '1;
      ptr_sync_r <= '1;
    end else begin
      kbd_meta_r <= kbd_pin_in;
      kbd_sync_r <= kbd_meta_r;
      ptr_meta_r <= ptr_pin_in;
      ptr_sync_r <= ptr_meta_r;
    end
  end

  // receive side follows the same swap as the drive side
  assign kbd_role_rx = swap ? ptr_sync_r : kbd_sync_r;
  assign mouse_role_rx = swap ? kbd_sync_r : ptr_sync_r;

  // drive enables, registered so the pins never glitch on a config write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      kbd_oe_r <= '0;
      ptr_oe_r <= '0;
    end else begin
      if (float_kbd_pins) begin
        kbd_oe_r <= '0;
      end else begin
        kbd_oe_r <= swap ? mouse_role_drive : kbd_role_drive;
      end
      if (float_mouse_pins) begin
        ptr_oe_r <= '0;
      end else begin
        ptr_oe_r <= swap ? kbd_role_drive : mouse_role_drive;
      end
    end
  end

endmodule

//--- logic/kbc_cfg_bank.sv
// configuration register bank of the keyboard and pointer input controller
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - inactive mouse device never asserts its selected interrupt line.
// - mouse activation leaves host command handling for the pointer untouched while the float bit is clear.
// - after reset keyboard activation is one, mouse activation is zero.
// - mouse interrupt number register is read/write, resets to twelve.
// - keyboard interrupt number register is read/write, resets to one.
// - mouse interrupt type: only bits 1:0 writable, resets to 02h.
// - keyboard interrupt type: only bits 1:0 writable, resets to 02h.
// - both no-DMA report registers per device read 04h, read-only.
// - base address high bytes: bits 7:3 read zero; rest writable, reset zero.
// - data port base low byte: bits 2:0 fixed 000b, resets to 60h.
// - command port base low byte: bits 2:0 fixed 100b, resets to 64h.
// - shared controller configuration register is read/write, resets to 40h.
// - clock source field: 00 8 MHz, 01 12 MHz, 10 16 MHz, 11 reserved.
// - swap bit exchanges the roles of keyboard and pointer pin pairs.
// - float bit set and keyboard inactive releases keyboard clock and data pins.
// - float bit set and mouse inactive releases pointer pins; bit resets zero.
module kbd_mouse_ctrl_config_bank
  import input_ctrl_cfg_pkg::*;
(
  input wire logic core_clk, // bus clock, 25 MHz
  input wire logic nrst, // async reset, active low
  // wishbone classic slave
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [WB_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [WB_DAT_W-1:0] wb_dat_i, // write data
  output logic [WB_DAT_W-1:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  // controller core side
  input wire logic kbd_irq_req, // keyboard interrupt from core
  input wire logic mouse_irq_req, // pointer interrupt from core
  input wire ps2_pair_t kbd_role_drive, // core pulls keyboard lines low
  input wire ps2_pair_t mouse_role_drive, // core pulls pointer lines low
  output ps2_pair_t kbd_role_rx, // keyboard line levels to core
  output ps2_pair_t mouse_role_rx, // pointer line levels to core
  output irq_out_t kbd_irq, // gated keyboard interrupt
  output irq_out_t mouse_irq, // gated pointer interrupt
  output logic keyboard_device_active, // keyboard logical device enabled
  output logic pointer_device_active, // pointer logical device enabled
  output clk_src_t input_controller_clk_sel, // core clock source
  output logic [15:0] kbd_data_port_base, // data port I/O base
  output logic [15:0] kbd_cmd_port_base, // command port I/O base
  // physical pins, open drain
  input wire ps2_pair_t kbd_pin_in, // keyboard pin levels
  output ps2_pair_t kbd_pin_out, // keyboard pin drive value
  output ps2_pair_t kbd_pin_oe, // keyboard pin enables
  input wire ps2_pair_t ptr_pin_in, // pointer pin levels
  output ps2_pair_t ptr_pin_out, // pointer pin drive value
  output ps2_pair_t ptr_pin_oe // pointer pin enables
);

  // ***************************************************************
  // bus slave state
  // ***************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  bus_state_t bus_state_r;
  bus_state_t bus_state_nxt;
  logic [WB_DAT_W-1:0] rdata_r;
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr_en;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] rd_byte;

  // ***************************************************************
  // register storage
  // ***************************************************************
  logic [7:0] dev_sel_r;
  logic mouse_act_r;
  logic kbd_act_r;
  logic [7:0] mouse_irq_num_r;
  logic [7:0] kbd_irq_num_r;
  logic [7:0] mouse_irq_type_r;
  logic [7:0] kbd_irq_type_r;
  logic [7:0] data_base_hi_r;
  logic [7:0] data_base_lo_r;
  logic [7:0] cmd_base_hi_r;
  logic [7:0] cmd_base_lo_r;
  logic [7:0] ctrl_cfg_r;
  irq_out_t kbd_irq_r;
  irq_out_t mouse_irq_r;

  // decoded selects
  logic sel_mouse;
  logic sel_kbd;
  logic swap;
  logic float_en;
  logic [7:0] cfg_merged;

  // ***************************************************************
  // address decode
  // ***************************************************************
  // word addressing: low two address bits are ignored
  assign idx = wb_adr_i[IDX_W+1:2];
  assign req = wb_cyc_i & wb_stb_i;
  assign wbyte = wb_dat_i[REG_W-1:0];
  // a write takes effect on the edge where the master sees ack
  assign wr_en = req & wb_we_i & wb_sel_i[0] & (bus_state_r == BUS_ACK);
  assign sel_mouse = (dev_sel_r == LD_MOUSE);
  assign sel_kbd = (dev_sel_r == LD_KEYBOARD);

  // ***************************************************************
  // wishbone handshake
  // ***************************************************************
  // one wait state: ack rises the cycle after the request, then drops
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  assign wb_ack_o = (bus_state_r == BUS_ACK);
  assign wb_dat_o = rdata_r;

  // ***************************************************************
  // read multiplexer
  // ***************************************************************
  // unmapped indices and unselected devices read as zero
  always_comb begin
    rd_byte = '0;
    if (idx == IDX_DEV_SEL) begin
      rd_byte = dev_sel_r;
    end else if (sel_mouse) begin
      case (idx)
        IDX_ACTIVATE: rd_byte = {7'h00, mouse_act_r};
        IDX_IRQ_NUM: rd_byte = mouse_irq_num_r;
        IDX_IRQ_TYPE: rd_byte = mouse_irq_type_r;
        IDX_NO_DMA_A: rd_byte = NO_DMA_VALUE;
        IDX_NO_DMA_B: rd_byte = NO_DMA_VALUE;
        default: rd_byte = '0;
      endcase
    end else if (sel_kbd) begin
      case (idx)
        IDX_ACTIVATE: rd_byte = {7'h00, kbd_act_r};
        IDX_DATA_BASE_HI: rd_byte = data_base_hi_r;
        IDX_DATA_BASE_LO: rd_byte = data_base_lo_r;
        IDX_CMD_BASE_HI: rd_byte = cmd_base_hi_r;
        IDX_CMD_BASE_LO: rd_byte = cmd_base_lo_r;
        IDX_IRQ_NUM: rd_byte = kbd_irq_num_r;
        IDX_IRQ_TYPE: rd_byte = kbd_irq_type_r;
        IDX_NO_DMA_A: rd_byte = NO_DMA_VALUE;
        IDX_NO_DMA_B: rd_byte = NO_DMA_VALUE;
        IDX_CTRL_CFG: rd_byte = ctrl_cfg_r;
        default: rd_byte = '0;
      endcase
    end
  end

  // read data captured with the request, held while ack stands
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (req && (bus_state_r == BUS_IDLE)) begin
      rdata_r <= {{(WB_DAT_W-REG_W){1'b0}}, rd_byte};
    end
  end

  // ***************************************************************
  // logical device select
  // ***************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dev_sel_r <= RST_DEV_SEL;
    end else if (wr_en && (idx == IDX_DEV_SEL)) begin
      dev_sel_r <= wbyte;
    end
  end

  // ***************************************************************
  // activation
  // ***************************************************************
  // only bit 0 is stored; the rest of the byte reads zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mouse_act_r <= RST_MOUSE_ACT;
      kbd_act_r <= RST_KBD_ACT;
    end else if (wr_en && (idx == IDX_ACTIVATE)) begin
      if (sel_mouse) begin
        mouse_act_r <= wbyte[ACT_BIT];
      end
      if (sel_kbd) begin
        kbd_act_r <= wbyte[ACT_BIT];
      end
    end
  end

  // ***************************************************************
  // interrupt number and type
  // ***************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mouse_irq_num_r <= RST_MOUSE_IRQ_NUM;
      kbd_irq_num_r <= RST_KBD_IRQ_NUM;
    end else if (wr_en && (idx == IDX_IRQ_NUM)) begin
      if (sel_mouse) begin
        mouse_irq_num_r <= wbyte;
      end
      if (sel_kbd) begin
        kbd_irq_num_r <= wbyte;
      end
    end
  end

  // upper type bits stay at their fixed value whatever is written
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mouse_irq_type_r <= RST_IRQ_TYPE;
      kbd_irq_type_r <= RST_IRQ_TYPE;
    end else if (wr_en && (idx == IDX_IRQ_TYPE)) begin
      if (sel_mouse) begin
        mouse_irq_type_r <= wmerge(IRQ_TYPE_FIXED, wbyte, IRQ_TYPE_WMASK);
      end
      if (sel_kbd) begin
        kbd_irq_type_r <= wmerge(IRQ_TYPE_FIXED, wbyte, IRQ_TYPE_WMASK);
      end
    end
  end

  // ***************************************************************
  // keyboard port base addresses
  // ***************************************************************
  // fixed bits come from constants so a stray write cannot reach them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_base_hi_r <= RST_DATA_BASE_HI;
      data_base_lo_r <= RST_DATA_BASE_LO;
      cmd_base_hi_r <= RST_CMD_BASE_HI;
      cmd_base_lo_r <= RST_CMD_BASE_LO;
    end else if (wr_en && sel_kbd) begin
      case (idx)
        IDX_DATA_BASE_HI: data_base_hi_r <= wmerge(BASE_HI_FIXED, wbyte, BASE_HI_WMASK);
        IDX_DATA_BASE_LO: begin
          data_base_lo_r <= wmerge(DATA_BASE_LO_FIXED, wbyte, BASE_LO_WMASK);
        end
        IDX_CMD_BASE_HI: cmd_base_hi_r <= wmerge(BASE_HI_FIXED, wbyte, BASE_HI_WMASK);
        IDX_CMD_BASE_LO: begin
          cmd_base_lo_r <= wmerge(CMD_BASE_LO_FIXED, wbyte, BASE_LO_WMASK);
        end
        default: begin
        end
      endcase
    end
  end

  assign kbd_data_port_base = {data_base_hi_r, data_base_lo_r};
  assign kbd_cmd_port_base = {cmd_base_hi_r, cmd_base_lo_r};

  // ***************************************************************
  // shared controller configuration
  // ***************************************************************
  // reserved bits 5:4 and 2:1 are masked off on every write; a write of
  // the reserved clock code keeps the previous source so the core clock
  // never lands on an undefined setting
  assign cfg_merged = wmerge(ctrl_cfg_r, wbyte, CTRL_CFG_WMASK);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_cfg_r <= RST_CTRL_CFG;
    end else if (wr_en && sel_kbd && (idx == IDX_CTRL_CFG)) begin
      if (wbyte[CFG_CLK_MSB:CFG_CLK_LSB] == CLK_RSVD) begin
        ctrl_cfg_r <= {ctrl_cfg_r[CFG_CLK_MSB:CFG_CLK_LSB],
                       cfg_merged[CFG_CLK_LSB-1:0]};
      end else begin
        ctrl_cfg_r <= cfg_merged;
      end
    end
  end

  // the core clock follows the field at once; keeping the devices idle
  // around a change is left to software
  assign input_controller_clk_sel = clk_src_t'(ctrl_cfg_r[CFG_CLK_MSB:CFG_CLK_LSB]);
  assign swap = ctrl_cfg_r[CFG_SWAP_BIT];
  assign float_en = ctrl_cfg_r[CFG_FLOAT_BIT];

  assign keyboard_device_active = kbd_act_r;
  assign pointer_device_active = mouse_act_r;

  // ***************************************************************
  // interrupt gating
  // ***************************************************************
  // an inactive device holds its line low; number and type travel along
  // so the interrupt router needs no access to this bank
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      kbd_irq_r <= '0;
      mouse_irq_r <= '0;
    end else begin
      kbd_irq_r.num <= kbd_irq_num_r;
      kbd_irq_r.kind <= kbd_irq_type_r[1:0];
      kbd_irq_r.req <= kbd_irq_req & kbd_act_r;
      mouse_irq_r.num <= mouse_irq_num_r;
      mouse_irq_r.kind <= mouse_irq_type_r[1:0];
      mouse_irq_r.req <= mouse_irq_req & mouse_act_r;
    end
  end

  assign kbd_irq = kbd_irq_r;
  assign mouse_irq = mouse_irq_r;

  // ***************************************************************
  // pin routing
  // ***************************************************************
  // pointer line receive is never gated by mouse activation, and drive is gated only while the
  // float bit is set, so host commands aimed at the pointer keep working with the float bit clear
  ps2_pin_router u_pins (
    .core_clk(core_clk),
    .nrst(nrst),
    .swap(swap),
    .float_kbd_pins(float_en & ~kbd_act_r),
    .float_mouse_pins(float_en & ~mouse_act_r),
    .kbd_role_drive(kbd_role_drive),
    .mouse_role_drive(mouse_role_drive),
    .kbd_role_rx(kbd_role_rx),
    .mouse_role_rx(mouse_role_rx),
    .kbd_pin_in(kbd_pin_in),
    .kbd_pin_out(kbd_pin_out),
    .kbd_pin_oe(kbd_pin_oe),
    .ptr_pin_in(ptr_pin_in),
    .ptr_pin_out(ptr_pin_out),
    .ptr_pin_oe(ptr_pin_oe)
  );

endmodule

//--- verification/kbc_cfg_bank_props.sv
// assertion checker for the input controller configuration bank
`timescale 1ns/1ps
module kbd_mouse_ctrl_config_bank_props
  import input_ctrl_cfg_pkg::*;
(
  input wire logic core_clk, // bus clock
  input wire logic nrst, // async reset, active low
  input wire logic wb_we_i, // write enable
  input wire logic [WB_DAT_W-1:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic mouse_irq_req, // pointer request
  input wire irq_out_t mouse_irq, // gated pointer interrupt
  input wire logic keyboard_device_active, // keyboard enabled
  input wire logic pointer_device_active, // pointer enabled
  input wire clk_src_t input_controller_clk_sel, // clock source
  input wire logic [15:0] kbd_data_port_base, // data port base
  input wire logic [15:0] kbd_cmd_port_base // command port base
);
  // ***********************
  // checks
  // ***********************
  // single clock domain, so one clocking and one disable serve all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  irq_gate_a: assert property (
    !pointer_device_active |=> !mouse_irq.req) else $error("pointer irq while inactive");
  irq_pass_a: assert property (
    mouse_irq_req && pointer_device_active |=> mouse_irq.req) else $error("pointer irq lost");
  reset_act_a: assert property (
    $rose(nrst) |-> keyboard_device_active && !pointer_device_active) else $error("bad act");
  clk_legal_a: assert property (
    input_controller_clk_sel != CLK_RSVD) else $error("reserved clock source");
  base_hi_a: assert property (
    kbd_data_port_base[15:11] == 5'h00 && kbd_cmd_port_base[15:11] == 5'h00)
    else $error("base high bits set");
  data_lo_a: assert property (
    kbd_data_port_base[2:0] == 3'h0) else $error("data base low bits");
  cmd_lo_a: assert property (
    kbd_cmd_port_base[2:0] == 3'h4) else $error("command base low bits");
  cfg_hold_a: assert property (
    $changed(input_controller_clk_sel) |-> $past(wb_ack_o && wb_we_i))
    else $error("clock source changed without write");
  base_hold_a: assert property (
    $changed(kbd_data_port_base) || $changed(kbd_cmd_port_base) |-> $past(wb_ack_o && wb_we_i))
    else $error("base changed without write");
  rd_upper_a: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind kbd_mouse_ctrl_config_bank kbd_mouse_ctrl_config_bank_props i_props (.core_clk, .nrst,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .mouse_irq_req, .mouse_irq, .keyboard_device_active,
  .pointer_device_active, .input_controller_clk_sel, .kbd_data_port_base, .kbd_cmd_port_base);

//--- verification/kbc_cfg_bank_tb.sv
// self-checking bench for the input controller configuration bank
`timescale 1ns/1ps
module kbd_mouse_ctrl_config_bank_tb;
  import input_ctrl_cfg_pkg::*;
  logic core_clk, nrst, cyc, stb, we, kirq, mirq, ack, kact, pact;
  logic [WB_ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [WB_DAT_W-1:0] wdat, rdat;
  logic [7:0] q;
  ps2_pair_t kdrv, mdrv, krx, mrx, kin, pin, kout, koe, pout, poe;
  irq_out_t kirq_o, mirq_o;
  clk_src_t csel;
  logic [15:0] dbase, cbase;
  logic [31:0] tab[$];
  int num_errors = 0;
  int n_checks = 0;
  kbd_mouse_ctrl_config_bank i_kbd_mouse_ctrl_config_bank (.core_clk(core_clk),
    .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .kbd_irq_req(kirq), .mouse_irq_req(mirq),
    .kbd_role_drive(kdrv), .mouse_role_drive(mdrv), .kbd_role_rx(krx), .mouse_role_rx(mrx),
    .kbd_irq(kirq_o), .mouse_irq(mirq_o), .keyboard_device_active(kact),
    .pointer_device_active(pact), .input_controller_clk_sel(csel),
    .kbd_data_port_base(dbase), .kbd_cmd_port_base(cbase), .kbd_pin_in(kin),
    .kbd_pin_out(kout), .kbd_pin_oe(koe), .ptr_pin_in(pin), .ptr_pin_out(pout),
    .ptr_pin_oe(poe));
  // ***********************
  // helpers
  // ***********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; entered just after a rising edge; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  // table entry: write flag, index, write data, expected read back
  task automatic run_tab();
    foreach (tab[i]) begin
      if (tab[i][24]) wb(1'b1, tab[i][23:16], tab[i][15:8]);
      wb(1'b0, tab[i][23:16], 8'h00);
      chk(q, tab[i][7:0]);
    end
    tab = {};
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ***********************
  // clock, watchdog, tests
  // ***********************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // all tests take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
  initial begin
    {nrst, cyc, stb, we, kirq, mirq, adr, wdat} = '0;
    sel = 4'hF;
    {kdrv, mdrv} = '0;
    {kin, pin} = 4'hF;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // reset values, read-only and unmapped reads
    tab = '{32'h01070606, 32'h00300001, 32'h00600000, 32'h00610060, 32'h00620000,
      32'h00630064, 32'h00700001, 32'h00710002, 32'h00740004, 32'h00750004, 32'h00F00040,
      32'h00400000, 32'h01070505, 32'h00300000, 32'h0070000C, 32'h00710002, 32'h00740004,
      32'h00750004};
    run_tab();
    $display("test reset values done");
    mirq <= 1'b1;
    kirq <= 1'b1;
    pin <= 2'b10;
    repeat (3) @(posedge core_clk);
    chk({mirq_o.req, mirq_o.num, mrx}, {1'b0, 8'h0C, 2'b10});
    chk({kact, kirq_o.req, kirq_o.kind, mirq_o.kind, kout, pout}, 10'h3A0);
    wb(1'b1, IDX_ACTIVATE, 8'h01);
    repeat (2) @(posedge core_clk);
    chk({pact, mirq_o.req, mrx}, 4'hE);
    wb(1'b1, IDX_ACTIVATE, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(mirq_o.req, 1'b0);
    $display("test interrupt gating done");
    // writes of ones and of patterns such as A5h, FEh, 5Ah and FCh, fixed bits stay
    tab = '{32'h0170A5A5, 32'h0171FF03, 32'h0174FF04, 32'h0175FF04, 32'h01070606,
      32'h0130FE00, 32'h0160FF07, 32'h0161FFF8, 32'h0162FF07, 32'h0163FFFC, 32'h01705A5A,
      32'h0171FC00, 32'h0174FF04, 32'h0175FF04, 32'h01F0FF49};
    run_tab();
    chk({dbase, cbase}, 32'h07F807FC);
    chk({csel, kirq_o.num, kact, kirq_o.req}, {CLK_12MHZ, 8'h5A, 2'b00});
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, IDX_CTRL_CFG, 8'(k << 6));
      chk(csel, k);
    end
    $display("test register writes done");
    kdrv <= 2'b11;
    repeat (3) @(posedge core_clk);
    chk({koe, poe}, 4'hC);
    wb(1'b1, IDX_CTRL_CFG, 8'h09);
    repeat (2) @(posedge core_clk);
    chk({koe, poe}, 4'h0);
    wb(1'b1, IDX_CTRL_CFG, 8'h08);
    repeat (3) @(posedge core_clk);
    chk({koe, poe, krx}, 6'h0E);
    wb(1'b1, IDX_CTRL_CFG, 8'h01);
    wb(1'b1, IDX_ACTIVATE, 8'h01);
    repeat (2) @(posedge core_clk);
    chk({koe, poe}, 4'hC);
    $display("test pin routing done");
    close_out();
  end
endmodule
